// File: hdl/sofe_servo_core.v
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "sofe_defs.vh"

module sofe_servo_core #(
  parameter NFUNC      = 13,
  parameter COUNTS_REV = 4096
) (
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [NFUNC-1:0] fnActive,
  input  wire        pulseStep,
  input  wire        pulseDir,
  input  wire        velStep,
  input  wire        velDir,
  input  wire        encStep,
  input  wire        encDir,
  output reg  [2:0]  outLine,
  output wire        followFault,
  output wire        irq
);

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  reg  [31:0] ctrl;
  reg  [2*NFUNC-1:0] lineMap;
  reg  [2:0]  linePol;
  reg  [31:0] feLimit;
  reg  [31:0] pulseCount;
  reg  [31:0] cmdPos;
  reg  [31:0] encPos;
  reg  [31:0] fbZero;
  reg  [1:0]  status;
  reg  [1:0]  intEn;
  reg         prevEnable;

  wire [1:0]  mode      = ctrl[`SOFE_CTRL_MODE_HI:`SOFE_CTRL_MODE_LO];
  wire        driveEn   = ctrl[`SOFE_CTRL_ENABLE];
  wire        feEnable  = ctrl[`SOFE_CTRL_FEEN];

  // ----------------------------------------------------------------------
  // write channel: address and data taken in either order
  // ----------------------------------------------------------------------
  reg         awHeld;
  reg         wHeld;
  reg  [7:0]  awAddr;
  reg  [31:0] wData;
  reg  [3:0]  wStrb;
  reg         awHigh;

  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;

  wire        awNow  = awHeld | s_axi_awvalid;
  wire        wNow   = wHeld | s_axi_wvalid;
  wire [7:0]  wrAddr = awHeld ? awAddr : s_axi_awaddr[7:0];
  wire [31:0] wrData = wHeld ? wData : s_axi_wdata;
  wire [3:0]  wrStrb = wHeld ? wStrb : s_axi_wstrb;
  // only the low byte is decoded; any upper bit set is out of map
  wire        wrHigh = awHeld ? awHigh : (|s_axi_awaddr[31:8]);
  wire        wrFire = awNow && wNow && !s_axi_bvalid;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  be;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        merge[8*k +: 8] = be[k] ? nw[8*k +: 8] : old[8*k +: 8];
      end
    end
  endfunction

  function mapped;
    input [7:0] a;
    begin
      mapped = (a <= `SOFE_A_ZEROFB) && (a[1:0] == 2'h0);
    end
  endfunction

  wire        wrOk     = mapped(wrAddr) && !wrHigh;
  wire        wrHit    = wrFire && wrOk;
  wire [31:0] limitNew = merge(feLimit, wrData, wrStrb);
  wire        wrEnc    = wrHit && (wrAddr == `SOFE_A_ENCPOS);
  wire        wrZero   = wrHit && (wrAddr == `SOFE_A_ZEROFB);

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld       <= 1'b0;
      wHeld        <= 1'b0;
      awAddr       <= 8'h00;
      awHigh       <= 1'b0;
      wData        <= 32'h0000_0000;
      wStrb        <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SOFE_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr[7:0];
        awHigh <= |s_axi_awaddr[31:8];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrOk ? `SOFE_RESP_OKAY : `SOFE_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl    <= `SOFE_CTRL_RST;
      lineMap <= {(2*NFUNC){1'b0}};
      linePol <= 3'h0;
      feLimit <= `SOFE_FEL_RST;
      intEn   <= 2'h0;
    end else if (wrHit) begin
      case (wrAddr)
        `SOFE_A_CTRL:  ctrl    <= merge(ctrl, wrData, wrStrb);
        `SOFE_A_MAP:   lineMap <= wrData[2*NFUNC-1:0];
        `SOFE_A_POL:   linePol <= wrData[2:0];
        `SOFE_A_INTEN: intEn   <= wrData[1:0];
        `SOFE_A_FELIMIT: begin
          // out-of-range writes are clamped, not dropped
          if (limitNew < `SOFE_FEL_MIN)
            feLimit <= `SOFE_FEL_MIN;
          else if (limitNew > `SOFE_FEL_MAX)
            feLimit <= `SOFE_FEL_MAX;
          else
            feLimit <= limitNew;
        end
        default: ctrl <= ctrl;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // position tracking
  // ----------------------------------------------------------------------
  function [31:0] stepped;
    input [31:0] v;
    input        st;
    input        dn;
    begin
      if (!st)
        stepped = v;
      else if (dn)
        stepped = v - 32'h0000_0001;
      else
        stepped = v + 32'h0000_0001;
    end
  endfunction

  wire usePulse = (mode == `SOFE_MODE_PULSE) || (mode == `SOFE_MODE_SUM);
  wire useVel   = (mode == `SOFE_MODE_VEL) || (mode == `SOFE_MODE_SUM);
  reg  [31:0] next_cmdPos;
  // the write or step landing on this edge is already seen, so a
  // disabled drive leaves no stray count of error behind
  wire [31:0] next_encPos = wrEnc ? merge(encPos, wrData, wrStrb)
                                  : stepped(encPos, encStep, encDir);
  wire [31:0] next_fbZero = wrZero ? next_encPos : fbZero;

  always @* begin
    next_cmdPos = cmdPos;
    if (usePulse)
      next_cmdPos = stepped(next_cmdPos, pulseStep, pulseDir);
    if (useVel)
      next_cmdPos = stepped(next_cmdPos, velStep, velDir);
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulseCount <= 32'h0000_0000;
      cmdPos     <= 32'h0000_0000;
      encPos     <= 32'h0000_0000;
      fbZero     <= 32'h0000_0000;
      prevEnable <= 1'b0;
    end else begin
      prevEnable <= driveEn;
      if (pulseStep)
        pulseCount <= pulseCount + 32'h0000_0001;
      encPos <= next_encPos;
      if (wrZero)
        fbZero <= next_encPos;
      // while disabled the command tracks feedback, so no error builds
      if (!driveEn)
        cmdPos <= next_encPos - next_fbZero;
      else
        cmdPos <= next_cmdPos;
    end
  end

  // ----------------------------------------------------------------------
  // following error and limit
  // ----------------------------------------------------------------------
  wire [31:0] fbPos   = encPos - fbZero;
  wire [31:0] fErr    = cmdPos - fbPos;
  wire [31:0] fErrAbs = fErr[31] ? (32'h0000_0000 - fErr) : fErr;
  // limit is milli-revolutions; compare counts*1000 against limit*cpr
  wire [63:0] errScaled = {32'h0000_0000, fErrAbs} * `SOFE_FEL_SCALE;
  wire [63:0] limScaled = {32'h0000_0000, feLimit} * COUNTS_REV;
  wire        feTrip    = driveEn && feEnable
                          && (mode == `SOFE_MODE_PULSE)
                          && (errScaled > limScaled);
  wire        disEvent  = prevEnable && !driveEn;

  // ----------------------------------------------------------------------
  // status and interrupt
  // ----------------------------------------------------------------------
  wire [1:0] clrBits = (wrHit && wrAddr == `SOFE_A_INTCLR) ? wrData[1:0]
                                                           : 2'h0;
  wire [1:0] setBits = {disEvent, feTrip};

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      status <= 2'h0;
    else
      status <= (status & ~clrBits) | setBits;
  end

  assign followFault = status[`SOFE_ST_FAULT];
  assign irq         = |(status & intEn);

  // ----------------------------------------------------------------------
  // output line mapping
  // ----------------------------------------------------------------------
  reg [2:0] lineOr;
  integer   f;

  always @* begin
    lineOr = 3'h0;
    for (f = 0; f < NFUNC; f = f + 1) begin
      case (lineMap[2*f +: 2])
        `SOFE_LINE_1: lineOr[0] = lineOr[0] | fnActive[f];
        `SOFE_LINE_2: lineOr[1] = lineOr[1] | fnActive[f];
        `SOFE_LINE_3: lineOr[2] = lineOr[2] | fnActive[f];
        default: lineOr = lineOr;
      endcase
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      outLine <= 3'h0;
    else
      outLine <= lineOr ^ linePol;
  end

  // ----------------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------------
  wire [7:0]  rdAddr = s_axi_araddr[7:0];
  wire        rdOk   = mapped(rdAddr) && !(|s_axi_araddr[31:8]);
  reg  [31:0] rdVal;
  wire [31:0] fbRev  = fbPos / COUNTS_REV;
  wire [31:0] fbFrac = fbPos - fbRev * COUNTS_REV;

  assign s_axi_arready = !s_axi_rvalid;

  always @* begin
    case (rdAddr)
      `SOFE_A_CTRL:     rdVal = ctrl;
      `SOFE_A_MAP:      rdVal = {{(32-2*NFUNC){1'b0}}, lineMap};
      `SOFE_A_POL:      rdVal = {29'h0, linePol};
      `SOFE_A_FNSTATE:  rdVal = {{(32-NFUNC){1'b0}}, fnActive};
      `SOFE_A_FELIMIT:  rdVal = feLimit;
      `SOFE_A_PULSECNT: rdVal = pulseCount;
      `SOFE_A_CMDPOS:   rdVal = cmdPos;
      `SOFE_A_FERR:     rdVal = fErr;
      `SOFE_A_ENCPOS:   rdVal = encPos;
      `SOFE_A_FBPOS:    rdVal = fbPos;
      `SOFE_A_FBREV:    rdVal = fbRev;
      `SOFE_A_FBFRAC:   rdVal = fbFrac;
      `SOFE_A_STATUS:   rdVal = {30'h0, status};
      `SOFE_A_INTEN:    rdVal = {30'h0, intEn};
      `SOFE_A_LINES:    rdVal = {29'h0, outLine};
      default:          rdVal = 32'h0000_0000;
    endcase
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `SOFE_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdOk ? rdVal : 32'h0000_0000;
      s_axi_rresp  <= rdOk ? `SOFE_RESP_OKAY : `SOFE_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// File: hdl/sofe_defs.vh
`ifndef SOFE_DEFS_VH
`define SOFE_DEFS_VH

// register byte addresses
`define SOFE_A_CTRL      8'h00
`define SOFE_A_MAP       8'h04
`define SOFE_A_POL       8'h08
`define SOFE_A_FNSTATE   8'h0C
`define SOFE_A_FELIMIT   8'h10
`define SOFE_A_PULSECNT  8'h14
`define SOFE_A_CMDPOS    8'h18
`define SOFE_A_FERR      8'h1C
`define SOFE_A_ENCPOS    8'h20
`define SOFE_A_FBPOS     8'h24
`define SOFE_A_FBREV     8'h28
`define SOFE_A_FBFRAC    8'h2C
`define SOFE_A_STATUS    8'h30
`define SOFE_A_INTEN     8'h34
`define SOFE_A_INTCLR    8'h38
`define SOFE_A_LINES     8'h3C
`define SOFE_A_ZEROFB    8'h40

// control register fields
`define SOFE_CTRL_MODE_LO 0
`define SOFE_CTRL_MODE_HI 1
`define SOFE_CTRL_ENABLE  2
`define SOFE_CTRL_FEEN    3
`define SOFE_CTRL_RST     32'h0000_0000

// operating modes
`define SOFE_MODE_PULSE  2'h0
`define SOFE_MODE_VEL    2'h1
`define SOFE_MODE_SUM    2'h2
`define SOFE_MODE_TORQUE 2'h3

// limit in thousandths of a revolution
`define SOFE_FEL_MIN     32'd1
`define SOFE_FEL_MAX     32'd10000
`define SOFE_FEL_RST     32'd200
// milli-revolutions in one revolution
`define SOFE_FEL_SCALE   64'h0000_0000_0000_03E8

// line codes in the function map
`define SOFE_LINE_1      2'h1
`define SOFE_LINE_2      2'h2
`define SOFE_LINE_3      2'h3

// status bits
`define SOFE_ST_FAULT    0
`define SOFE_ST_DISABLE  1

`define SOFE_RESP_OKAY   2'h0
`define SOFE_RESP_SLVERR 2'h2

`endif

// File: bench/sofe_motion_src.sv
`timescale 1ns/1ps
// ---------------------------------------------------------
// step source standing in for pulse input, velocity and encoder
// ---------------------------------------------------------
module sofe_motion_src (
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire        start,
  input  wire [1:0]  sel,
  input  wire        dir,
  input  wire [15:0] count,
  output wire        pulseStep,
  output wire        pulseDir,
  output wire        velStep,
  output wire        velDir,
  output wire        encStep,
  output wire        encDir,
  output wire        busy
);
  reg [15:0] left;
  reg [1:0]  src;
  reg        ph;
  reg        d;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      left <= 16'h0000;
      src <= 2'h0;
      ph <= 1'b0;
      d <= 1'b0;
    end else if (start) begin
      left <= count;
      src <= sel;
      d <= dir;
      ph <= 1'b0;
    end else if (busy) begin
      ph <= ~ph;
      if (ph) left <= left - 16'h0001;
    end else begin
      // direction is not held between bursts, so it never looks stable
      d <= ~d;
    end
  end
  assign busy      = (left != 16'h0000);
  assign pulseStep = busy && !ph && (src == 2'h0);
  assign velStep   = busy && !ph && (src == 2'h1);
  assign encStep   = busy && !ph && (src == 2'h2);
  assign pulseDir  = d;
  assign velDir    = d;
  assign encDir    = d;
endmodule

// File: bench/sofe_servo_core_assertions.sv
`timescale 1ns/1ps
module sofe_servo_core_assertions (
  input wire        core_clk,
  input wire        rst_n,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        followFault,
  input wire        irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read not answered");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> s_axi_bvalid && !s_axi_awready)
    else $error("write not answered");
  ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  aw_refuse_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr > 32'h00000040 |=> s_axi_rresp == 2'h2 &&
    s_axi_rdata == 32'h00000000) else $error("unmapped read");
  fault_sticky_a: assert property (
    followFault && !s_axi_wvalid && !$past(s_axi_wvalid) |=> followFault)
    else $error("fault dropped without clear");
  irq_hold_a: assert property (irq && !s_axi_wvalid &&
    !$past(s_axi_wvalid) |=> irq) else $error("irq dropped");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property ($rose(followFault));
  cover property ($rose(irq));
endmodule
bind sofe_servo_core sofe_servo_core_assertions u_chk (.*);

// File: bench/sofe_servo_core_tb.sv
`timescale 1ns/1ps
`include "sofe_defs.vh"
module sofe_servo_core_tb;
  localparam CR = 16;
  localparam LIM = 250;
  reg         core_clk = 0;
  reg         rst_n = 0;
  reg  [31:0] awaddr = 0, wdata = 0, araddr = 0;
  reg         awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  reg  [12:0] fnActive = 0;
  reg         start = 0, dir = 0;
  reg  [1:0]  sel = 0;
  reg  [15:0] cnt = 0;
  wire        awready, wready, bvalid, arready, rvalid, busy, irq;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire        pS, pD, vS, vD, eS, eD, followFault;
  wire [2:0]  outLine;
  int         badCount = 0, checkCount = 0, i;
  int         cmd = 0, enc = 0, zref = 0, pcnt = 0, mode = 0, en = 0;
  reg  [31:0] m, p, rv;
  reg  [1:0]  rr, wb;
  sofe_servo_core #(.NFUNC(13), .COUNTS_REV(CR)) u_sofe_servo_core (
    .core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .fnActive(fnActive), .pulseStep(pS),
    .pulseDir(pD), .velStep(vS), .velDir(vD), .encStep(eS), .encDir(eD),
    .outLine(outLine), .followFault(followFault), .irq(irq));
  sofe_motion_src u_src (.core_clk(core_clk), .rst_n(rst_n), .start(start),
    .sel(sel), .dir(dir), .count(cnt), .pulseStep(pS), .pulseDir(pD),
    .velStep(vS), .velDir(vD), .encStep(eS), .encDir(eD), .busy(busy));
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  task closeOut;
    if (badCount == 0 && checkCount > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input [31:0] g, input [31:0] e);
    checkCount++;
    if (g !== e) begin
      badCount++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge core_clk);
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    wb = bresp;
    bready <= 1'b0;
  endtask
  task rd(input [7:0] a);
    @(posedge core_clk);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rv = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask
  task rchk(input [7:0] a, input [31:0] e);
    rd(a);
    chk(rv, e);
  endtask
  // drive mode and enable; a disabled drive makes command track feedback
  task setc(input int md, input int e, input int fe);
    wr(`SOFE_A_CTRL, md | (e << 2) | (fe << 3));
    mode = md;
    en = e;
    if (!e) cmd = enc - zref;
  endtask
  task st(input [1:0] s, input dr, input [15:0] n);
    int dl;
    dl = dr ? -n : n;
    @(posedge core_clk);
    start <= 1'b1;
    sel <= s;
    dir <= dr;
    cnt <= n;
    @(posedge core_clk);
    start <= 1'b0;
    @(posedge core_clk);
    while (busy) @(posedge core_clk);
    repeat (2) @(posedge core_clk);
    if (s == 0) pcnt += n;
    if (s == 0 && en && (mode == 0 || mode == 2)) cmd += dl;
    if (s == 1 && en && (mode == 1 || mode == 2)) cmd += dl;
    if (s == 2) enc += dl;
    if (!en) cmd = enc - zref;
  endtask
  task chkAll;
    rchk(`SOFE_A_PULSECNT, pcnt);
    rchk(`SOFE_A_CMDPOS, cmd);
    rchk(`SOFE_A_FERR, cmd - (enc - zref));
    rchk(`SOFE_A_ENCPOS, enc);
    rchk(`SOFE_A_FBPOS, enc - zref);
  endtask
  function [2:0] lines(input [12:0] f, input [31:0] mp, input [31:0] pl);
    int k;
    lines = 3'h0;
    for (k = 0; k < 13; k++)
      if (f[k] && mp[2*k+:2] != 2'h0) lines[mp[2*k+:2] - 1] = 1'b1;
    lines = lines ^ pl[2:0];
  endfunction
  initial begin
    #100000;
    badCount++;
    closeOut;
  end
  initial begin
    m = $urandom(20);
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    rchk(`SOFE_A_FELIMIT, 200);
    rchk(`SOFE_A_ENCPOS, 0);
    rd(8'h44);
    chk(rr, `SOFE_RESP_SLVERR);
    chk(rv, 0);
    wr(8'h44, 32'h0000_0001);
    chk(wb, `SOFE_RESP_SLVERR);
    for (i = 0; i < 24; i++) begin
      m = $urandom & 32'h03FFFFFF;
      p = $urandom;
      wr(`SOFE_A_MAP, m);
      wr(`SOFE_A_POL, p);
      @(posedge core_clk);
      fnActive <= 13'($urandom);
      repeat (2) @(posedge core_clk);
      chk(outLine, lines(fnActive, m, p));
      rchk(`SOFE_A_LINES, lines(fnActive, m, p));
      rchk(`SOFE_A_FNSTATE, fnActive);
    end
    wr(`SOFE_A_FELIMIT, 0);
    rchk(`SOFE_A_FELIMIT, 1);
    wr(`SOFE_A_FELIMIT, 20000);
    rchk(`SOFE_A_FELIMIT, 10000);
    wr(`SOFE_A_FELIMIT, LIM);
    chk(wb, `SOFE_RESP_OKAY);
    setc(3, 0, 0);
    st(0, 0, 7);
    chkAll;
    setc(1, 1, 1);
    st(1, 0, 9);
    st(2, 0, 1);
    chkAll;
    chk(followFault, 0);
    setc(1, 0, 1);
    chkAll;
    setc(2, 1, 1);
    st(0, 0, 3);
    st(1, 0, 4);
    chkAll;
    setc(0, 0, 0);
    setc(0, 1, 0);
    st(0, 0, 9);
    chk(followFault, 0);
    setc(0, 0, 1);
    setc(0, 1, 1);
    st(0, 0, LIM * CR / 1000);
    chk(followFault, 0);
    st(0, 0, 1);
    chk(followFault, 1);
    rchk(`SOFE_A_STATUS, 3);
    wr(`SOFE_A_INTEN, 1);
    chk(irq, 1);
    wr(`SOFE_A_INTEN, 0);
    chk(irq, 0);
    wr(`SOFE_A_INTEN, 1);
    setc(0, 0, 1);
    wr(`SOFE_A_INTCLR, 1);
    chk({followFault, irq}, 0);
    rchk(`SOFE_A_STATUS, 2);
    wr(`SOFE_A_ENCPOS, 32'h7FFFFFFE);
    enc = 32'h7FFFFFFE;
    st(2, 0, 3);
    chkAll;
    wr(`SOFE_A_ZEROFB, 0);
    zref = enc;
    st(2, 0, 2 * CR + 5);
    rchk(`SOFE_A_FBREV, 2);
    rchk(`SOFE_A_FBFRAC, 5);
    st(2, 1, 40);
    chkAll;
    closeOut;
  end
endmodule
